//--- src/bfp_cfg.svh
// Constants of the bridge fault protection controller.
// Assumes inclusion by bare name; holds definitions only.
//
// What this block does
// - Outputs Hi-Z until both supplies good
// - Reset gives safe state, any supply order
// - Held pair gets weak pulldown, except half mode
// - Two flags are active-low open-drain outputs
// - Shutdown flag low on any shutdown
// - Warning flag low above warning temperature
// - Flag pair encodes warning and shutdown
// - Any held pair forces shutdown flag high
// - Any fault: Hi-Z at once, flag low
// - Undervoltage recovers by itself when cleared
// - Low bootstrap: repeated short high-side off
// - Recharge also on very high duty
// - Mode picks per-cycle limit or latched trip
// - Per-cycle: overcurrent ends rest of cycle
// - Per-cycle: hard short latches shutdown
// - Current protection independent per half-bridge
// - Latched trip: immediate shutdown, pair reset restores
// - Thermal shutdown latched until both pairs held
// - Held pair forces its four FETs Hi-Z
// - Pair release edge clears overcurrent shutdown
`ifndef BFP_CFG_SVH
`define BFP_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BFP_CTRL_OFS         32'h0000_0000
`define BFP_STATUS_OFS       32'h0000_0004
`define BFP_CTRL_LATCHED_BIT 0
`define BFP_CTRL_HALF_BIT    1
`define BFP_CTRL_RST         2'h0
`define BFP_ST_UV_BIT        0
`define BFP_ST_THERM_BIT     1
`define BFP_ST_WARN_BIT      2
`define BFP_ST_OC_LSB        4
`define BFP_ST_LIMIT_LSB     8
`define BFP_ST_RECH_LSB      12
`define BFP_ST_HOLD_LSB      16
`define BFP_ST_PIN_LSB       18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BFP_SENSE_RST        19'h7c000
`define BFP_PIN_RST          2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define BFP_CLK_NS           25
`define BFP_RECHARGE_NS      100
`define BFP_REARM_NS         1000
`define BFP_PWM_PERIOD_NS    20000
`define BFP_DUTY_MAX_PERMIL  995
`define BFP_RECHARGE_CYC ((`BFP_RECHARGE_NS + `BFP_CLK_NS - 1) / `BFP_CLK_NS)
`define BFP_REARM_CYC    ((`BFP_REARM_NS + `BFP_CLK_NS - 1) / `BFP_CLK_NS)
`define BFP_HIGH_MAX_CYC \
  ((`BFP_PWM_PERIOD_NS * `BFP_DUTY_MAX_PERMIL / 1000) / `BFP_CLK_NS)

`endif

//--- src/bfp_pkg.sv
// Types of the bridge fault protection controller.
// Assumes the constants header is compiled alongside.
package bfp_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SYNC_W = 27;          // Synchronised pin bits
  localparam int CNT_W  = 16;          // Counter width

  typedef logic [CNT_W-1:0] bfp_cnt_t;

  // Comparator results, one bit each
  typedef struct packed {
    logic [3:0] gate_uv;               // Gate supply low per bridge
    logic       common_uv;             // Common supply low
    logic       temp_warn;             // Above warning level
    logic       temp_shut;             // Above shutdown level
    logic [3:0] oc_det;                // Overcurrent per bridge
    logic [3:0] oc_short;              // Hard short per bridge
    logic [3:0] boot_low;              // Bootstrap too low
  } bfp_sense_t;

  // Gate commands; both off means Hi-Z
  typedef struct packed {
    logic [3:0] hs_on;                 // High-side FET on
    logic [3:0] ls_on;                 // Low-side FET on
    logic [3:0] pulldown_en;           // Weak output pulldown
  } bfp_drive_t;

  // Whole state of the controller
  typedef struct packed {
    logic [SYNC_W-1:0] s1;             // Sync stage one
    logic [SYNC_W-1:0] s2;             // Sync stage two
    logic [SYNC_W-1:0] s3;             // Sync stage three
    logic [SYNC_W-1:0] val;            // Accepted levels
    logic [1:0]        hold_prev;      // Previous pair holds
    logic [3:0]        oc_latch;       // Overcurrent shutdown
    logic [3:0]        limit;          // Cycle curtailed
    logic              therm_latch;    // Thermal shutdown
    bfp_cnt_t [3:0]    high_cnt;       // Cycles of high pwm
    bfp_cnt_t [3:0]    rech_cnt;       // Recharge and rearm
    logic [1:0]        ctrl;           // Control register
    bfp_drive_t        drive;          // Registered drive
    logic              fault_oe;       // Shutdown flag pull
    logic              warn_oe;        // Warning flag pull
    logic              aw_got;         // Write address held
    logic              w_got;          // Write data held
    logic [31:0]       awaddr;         // Held write address
    logic [31:0]       wdata;          // Held write data
    logic [3:0]        wstrb;          // Held strobes
    logic              bvalid;         // Write response out
    logic [1:0]        bresp;          // Write response code
    logic              rvalid;         // Read data out
    logic [31:0]       rdata;          // Read data
    logic [1:0]        rresp;          // Read response code
  } bfp_state_t;

endpackage

//--- src/bfp_ctrl.sv
// Protection and fault reporting logic of a four half-bridge stage.
// Assumes comparator results and pins are asynchronous to aclk.
`timescale 1ns/1ps
`include "bfp_cfg.svh"

module bfp_ctrl
  import bfp_pkg::*;
#(
  parameter int unsigned RECHARGE_CYC = `BFP_RECHARGE_CYC,
  parameter int unsigned REARM_CYC    = `BFP_REARM_CYC,
  parameter int unsigned HIGH_MAX_CYC = `BFP_HIGH_MAX_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Pins and comparators
  input  wire bfp_sense_t  sense,
  input  wire logic [3:0]  pwm_in,
  input  wire logic        pair_ab_hold_n,
  input  wire logic        pair_cd_hold_n,
  output bfp_drive_t       drive,
  input  wire logic        shutdown_n_in,
  output logic             shutdown_n_out,
  output logic             shutdown_n_oe,
  input  wire logic        thermal_warning_n_in,
  output logic             thermal_warning_n_out,
  output logic             thermal_warning_n_oe
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

  if (RECHARGE_CYC < 1 || REARM_CYC < 1 || HIGH_MAX_CYC < 1)
  begin : g_bad_min
    $error("bfp_ctrl: cycle counts must be at least one");
  end
  if (RECHARGE_CYC + REARM_CYC > CNT_MAX || HIGH_MAX_CYC > CNT_MAX)
  begin : g_bad_max
    $error("bfp_ctrl: cycle counts exceed counter width");
  end

  localparam bfp_cnt_t RECH_LOAD = CNT_W'(RECHARGE_CYC + REARM_CYC);
  localparam bfp_cnt_t REARM_LVL = CNT_W'(REARM_CYC);
  localparam bfp_cnt_t HIGH_MAX  = CNT_W'(HIGH_MAX_CYC);
  localparam bfp_cnt_t CNT_TOP   = CNT_W'(CNT_MAX);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // State and working signals
  // ----------------------------------------
  bfp_state_t  st;                     // Registered state
  bfp_state_t  next_st;                // Next state
  bfp_sense_t  sn;                     // Synchronised comparators
  logic [3:0]  pwm;                    // Synchronised pwm
  logic [1:0]  hold;                   // Pair released, {cd, ab}
  logic [1:0]  pins;                   // Flag pin levels
  logic [1:0]  rise;                   // Pair release edges
  logic [3:0]  kill;                   // Bridge forced Hi-Z
  logic [3:0]  rech;                   // Recharge active
  logic        uv_any;                 // Any supply low
  logic        latched;                // Latched trip mode
  logic        half;                   // Single half mode
  logic        fault;                  // Any shutdown present
  logic [31:0] status;                 // Status word

  // ----------------------------------------
  // Handshake outputs
  // ----------------------------------------
  // Accept address and data in either order
  assign awready = !st.aw_got && !st.bvalid;
  assign wready  = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  assign bresp  = st.bresp;
  assign bvalid = st.bvalid;
  assign rdata  = st.rdata;
  assign rresp  = st.rresp;
  assign rvalid = st.rvalid;
  assign drive  = st.drive;
  // Open drain: only ever pulls low
  assign shutdown_n_out        = 1'b0;
  assign shutdown_n_oe         = st.fault_oe;
  assign thermal_warning_n_out = 1'b0;
  assign thermal_warning_n_oe  = st.warn_oe;

  // ----------------------------------------
  // Next state logic
  // ----------------------------------------
  always_comb
  begin
    next_st = st;

    // Three stage sync; accept when stages two and three agree
    next_st.s1  = {thermal_warning_n_in, shutdown_n_in, pair_cd_hold_n,
                   pair_ab_hold_n, pwm_in, sense};
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    next_st.val = (st.s2 & st.s3) | (st.val & (st.s2 | st.s3));

    // Split accepted levels
    sn   = bfp_sense_t'(st.val[18:0]);
    pwm  = st.val[22:19];
    hold = st.val[24:23];
    pins = st.val[26:25];
    rise = hold & ~st.hold_prev;
    next_st.hold_prev = hold;

    // Mode and supply summary
    latched = st.ctrl[`BFP_CTRL_LATCHED_BIT];
    half    = st.ctrl[`BFP_CTRL_HALF_BIT];
    uv_any  = (|sn.gate_uv) | sn.common_uv;

    // Thermal shutdown latch; a new trip beats the clear
    if (sn.temp_shut)
    begin
      next_st.therm_latch = 1'b1;
    end
    else if (hold == 2'b00)
    begin
      next_st.therm_latch = 1'b0;
    end

    // Per bridge protection and drive
    for (int x = 0; x < 4; x++)
    begin
      // Bridge off on supply or thermal fault, its own overcurrent shutdown, or held pair
      kill[x] = uv_any | st.therm_latch | st.oc_latch[x]
              | ~hold[x / 2];
      rech[x] = st.rech_cnt[x] > REARM_LVL;

      // Overcurrent shutdown; trip wins over release edge
      if (hold[x / 2] && (latched ? sn.oc_det[x] : sn.oc_short[x]))
      begin
        next_st.oc_latch[x] = 1'b1;
      end
      else if (rise[x / 2])
      begin
        next_st.oc_latch[x] = 1'b0;
      end

      // Curtail until the pwm period ends
      if (!latched && sn.oc_det[x] && pwm[x])
      begin
        next_st.limit[x] = 1'b1;
      end
      else if (!pwm[x] || latched)
      begin
        next_st.limit[x] = 1'b0;
      end

      // Recharge pulse then rearm gap
      if (st.rech_cnt[x] != '0)
      begin
        next_st.rech_cnt[x] = st.rech_cnt[x] - 1'b1;
      end
      else if (!kill[x] && pwm[x] &&
               (sn.boot_low[x] || st.high_cnt[x] >= HIGH_MAX))
      begin
        next_st.rech_cnt[x] = RECH_LOAD;
      end

      // Count uninterrupted high time
      if (!pwm[x] || rech[x] || kill[x])
      begin
        next_st.high_cnt[x] = '0;
      end
      else if (st.high_cnt[x] != CNT_TOP)
      begin
        next_st.high_cnt[x] = st.high_cnt[x] + 1'b1;
      end

      // Gate commands
      next_st.drive.hs_on[x] = !kill[x] && pwm[x] && !st.limit[x]
                             && !rech[x];
      next_st.drive.ls_on[x] = !kill[x] && !st.limit[x]
                             && (!pwm[x] || rech[x]);
      next_st.drive.pulldown_en[x] = !hold[x / 2] && !half;
    end

    // Flag outputs
    fault = uv_any | st.therm_latch | (|st.oc_latch);
    next_st.fault_oe = fault && (hold == 2'b11);
    next_st.warn_oe  = sn.temp_warn;

    // Status word
    status = '0;
    status[`BFP_ST_UV_BIT]       = uv_any;
    status[`BFP_ST_THERM_BIT]    = st.therm_latch;
    status[`BFP_ST_WARN_BIT]     = sn.temp_warn;
    status[`BFP_ST_OC_LSB +: 4]    = st.oc_latch;
    status[`BFP_ST_LIMIT_LSB +: 4] = st.limit;
    status[`BFP_ST_RECH_LSB +: 4]  = rech;
    status[`BFP_ST_HOLD_LSB +: 2]  = hold;
    status[`BFP_ST_PIN_LSB +: 2]   = pins;

    // Write channel capture
    if (awvalid && awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end

    // Perform write once both halves held
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (st.awaddr == `BFP_CTRL_OFS)
      begin
        if (st.wstrb[0])
        begin
          next_st.ctrl = st.wdata[1:0];
        end
      end
      else if (st.awaddr != `BFP_STATUS_OFS)
      begin
        next_st.bresp = RESP_SLVERR;                          // Unmapped
      end
    end
    if (st.bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // Read channel
    if (arvalid && arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      if (araddr == `BFP_CTRL_OFS)
      begin
        next_st.rdata = {30'h0, st.ctrl};
      end
      else if (araddr == `BFP_STATUS_OFS)
      begin
        next_st.rdata = status;
      end
      else
      begin
        next_st.rdata = 32'h0;
        next_st.rresp = RESP_SLVERR;                          // Unmapped
      end
    end
    else if (st.rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
    end

    // Synchronous reset to safe constants
    if (!aresetn)
    begin
      next_st      = '0;
      next_st.val  = {`BFP_PIN_RST, 2'h0, 4'h0, `BFP_SENSE_RST};
      // Stages match the safe levels, so no false release after reset
      next_st.s1   = next_st.val;
      next_st.s2   = next_st.val;
      next_st.s3   = next_st.val;
      next_st.ctrl = `BFP_CTRL_RST;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

endmodule

//--- bench/bfp_ctrl_checker.sv
// Concurrent checks on the protection outputs of bfp_ctrl.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ps

module bfp_ctrl_checker
  import bfp_pkg::*;
#(
  parameter int unsigned RECHARGE_CYC = 4,
  parameter int unsigned REARM_CYC    = 40,
  parameter int unsigned HIGH_MAX_CYC = 796
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire bfp_sense_t sense,
  input wire logic [3:0] pwm_in,
  input wire logic       pair_ab_hold_n,
  input wire logic       pair_cd_hold_n,
  input wire bfp_drive_t drive,
  input wire logic       shutdown_n_out,
  input wire logic       shutdown_n_oe,
  input wire logic       thermal_warning_n_out,
  input wire logic       thermal_warning_n_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rel;  // Both pairs released
  assign rel = pair_ab_hold_n && pair_cd_hold_n;

  AST_UV_HIZ: assert property (sense.common_uv [*8] |->
    drive.hs_on == 4'h0 && drive.ls_on == 4'h0) else $error("Stage driven in undervoltage");
  AST_HOLD_AB: assert property ((!pair_ab_hold_n) [*8] |-> !shutdown_n_oe &&
    drive.hs_on[1:0] == 2'h0 && drive.ls_on[1:0] == 2'h0) else $error("Held pair ab active");
  AST_HOLD_CD: assert property ((!pair_cd_hold_n) [*8] |->
    drive.hs_on[3:2] == 2'h0 && drive.ls_on[3:2] == 2'h0) else $error("Held pair cd active");
  AST_PULLDOWN: assert property (drive.pulldown_en[0] |-> drive.pulldown_en[1] &&
    !drive.hs_on[0] && !drive.ls_on[0] && !shutdown_n_oe) else $error("Pulldown out of hold");
  AST_OPEN_DRAIN: assert property (!shutdown_n_out && !thermal_warning_n_out)
    else $error("Flag driven high");
  AST_WARN_ON: assert property (sense.temp_warn [*8] |-> thermal_warning_n_oe)
    else $error("Warning flag not pulled");
  AST_WARN_OFF: assert property ((!sense.temp_warn) [*8] |-> !thermal_warning_n_oe)
    else $error("Warning flag pulled without cause");
  AST_OC_TRIP: assert property ((rel && sense.oc_short[0]) [*8] |-> ##2
    (shutdown_n_oe && !drive.hs_on[0] && !drive.ls_on[0])) else $error("Short not tripped");
  AST_RECHARGE: assert property ((!pwm_in[0]) [*4] ##1
    (rel && pwm_in[0] && sense == 19'h00001 && !shutdown_n_oe) [*8] |->
    ##[0:60] (drive.ls_on[0] && !drive.hs_on[0])) else $error("No bootstrap recharge");
endmodule

bind bfp_ctrl bfp_ctrl_checker #(
  .RECHARGE_CYC(RECHARGE_CYC),
  .REARM_CYC   (REARM_CYC),
  .HIGH_MAX_CYC(HIGH_MAX_CYC)
) u_chk (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .sense                (sense),
  .pwm_in               (pwm_in),
  .pair_ab_hold_n       (pair_ab_hold_n),
  .pair_cd_hold_n       (pair_cd_hold_n),
  .drive                (drive),
  .shutdown_n_out       (shutdown_n_out),
  .shutdown_n_oe        (shutdown_n_oe),
  .thermal_warning_n_out(thermal_warning_n_out),
  .thermal_warning_n_oe (thermal_warning_n_oe)
);

//--- bench/bfp_host_model.sv
// Model of the external pwm controller driving pwm and pair holds.
// Assumes commands from the bench, changed just after aclk rises.
`timescale 1ns/1ps

module bfp_host_model
  import bfp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [1:0] hold_cmd,
  input  wire logic [3:0] pwm_cmd,
  input  wire logic       warn_pin,
  output logic [3:0]      pwm = 4'h0,
  output logic            ab_hold_n = 1'b0,
  output logic            cd_hold_n = 1'b0
);
  // Holds low at power-up, high in run, pulsed low to restore trips
  always @(posedge aclk)
  begin
    ab_hold_n <= hold_cmd[0];
    cd_hold_n <= hold_cmd[1];
    pwm       <= warn_pin ? pwm_cmd : 4'h0;
  end
endmodule

//--- bench/bridge_fault_protection_ctrl_tb.sv
// Self-checking bench of the bridge fault protection controller.
// Assumes package, header, checker and controller model compiled first.
`timescale 1ns/1ps
`include "bfp_cfg.svh"

`define CMP(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got); end end

module bridge_fault_protection_ctrl_tb
  import bfp_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, rng, r;
  logic [3:0]  wstrb, pwm_in, pwm_cmd;
  logic [1:0]  bresp, rresp, hold_cmd;
  logic        ab_n, cd_n, sd_oe, sd_out, tw_oe, tw_out, sd_pin, tw_pin;
  bfp_sense_t  sense;            // Comparator levels
  bfp_drive_t  drive;            // Gate commands
  int          error_cnt, compares;
  logic [33:0] exp_q[$], msk_q[$]; // Expected response and data

  assign sd_pin = sd_oe ? sd_out : 1'b1;  // Pullup resolves open drain
  assign tw_pin = tw_oe ? tw_out : 1'b1;

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  bfp_ctrl #(.RECHARGE_CYC(2), .REARM_CYC(4), .HIGH_MAX_CYC(20)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sense(sense), .pwm_in(pwm_in), .pair_ab_hold_n(ab_n),
    .pair_cd_hold_n(cd_n), .drive(drive), .shutdown_n_in(sd_pin), .shutdown_n_out(sd_out),
    .shutdown_n_oe(sd_oe), .thermal_warning_n_in(tw_pin), .thermal_warning_n_out(tw_out),
    .thermal_warning_n_oe(tw_oe));

  bfp_host_model u_host (.aclk(aclk), .hold_cmd(hold_cmd), .pwm_cmd(pwm_cmd),
    .warn_pin(tw_pin), .pwm(pwm_in), .ab_hold_n(ab_n), .cd_hold_n(cd_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] e);
    logic pa;
    logic pw;
    @(posedge aclk);
    exp_q.push_back({e, 32'h0});
    msk_q.push_back({2'h3, 32'h0});
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, d, m, input logic [1:0] e);
    @(posedge aclk);
    exp_q.push_back({e, d});
    msk_q.push_back({2'h3, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Status read over flags, latches, limits, holds and pins
  task automatic st(input logic [31:0] d);
    rd(`BFP_STATUS_OFS, d, 32'h000f_0ff7, 2'h0);
  endtask

  task automatic settle();
    repeat (10) @(posedge aclk);
  endtask

  task automatic results();
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Oldest note against each response
  task automatic chk(input logic [33:0] got);
    logic [33:0] e;
    logic [33:0] m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    `CMP(got & m, e & m)
  endtask

  always @(posedge aclk)
  begin
    if (aresetn && bvalid && bready)
      chk({bresp, 32'h0});
    if (aresetn && rvalid && rready)
      chk({rresp, rdata});
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    results();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, wdata, araddr} = 96'h0;
    {wstrb, pwm_cmd, hold_cmd} = 10'h0;
    sense = `BFP_SENSE_RST;
    {error_cnt, compares} = 64'h0;
    rng = 32'h0000_004f;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`BFP_CTRL_OFS, 32'h0, 32'hffff_ffff, 2'h0);
    r = xs();
    wr(`BFP_CTRL_OFS, r, 4'hf, 2'h0);
    rd(`BFP_CTRL_OFS, {30'h0, r[1:0]}, 32'hffff_ffff, 2'h0);
    wr(`BFP_CTRL_OFS, 32'h0, 4'he, 2'h0);
    rd(`BFP_CTRL_OFS, {30'h0, r[1:0]}, 32'hffff_ffff, 2'h0);
    wr(`BFP_CTRL_OFS, 32'h0, 4'hf, 2'h0);
    wr(32'h10, r, 4'hf, 2'h2);
    rd(32'h10, 32'h0, 32'hffff_ffff, 2'h2);
    wr(`BFP_STATUS_OFS, r, 4'hf, 2'h0);
    st(32'h000c_0001);
    hold_cmd <= 2'h3;
    settle();
    st(32'h000b_0001);
    sense.gate_uv <= 4'h0;
    sense.common_uv <= 1'b0;
    settle();
    st(32'h000f_0000);
    sense.temp_warn <= 1'b1;
    settle();
    st(32'h0007_0004);
    sense.temp_warn <= 1'b0;
    sense.oc_short[0] <= 1'b1;
    settle();
    st(32'h000b_0010);
    sense.oc_short[0] <= 1'b0;
    settle();
    st(32'h000b_0010);
    hold_cmd <= 2'h2;
    settle();
    hold_cmd <= 2'h3;
    settle();
    st(32'h000f_0000);
    wr(`BFP_CTRL_OFS, 32'h1, 4'hf, 2'h0);
    sense.oc_det[2] <= 1'b1;
    settle();
    st(32'h000b_0040);
    sense.oc_det[2] <= 1'b0;
    hold_cmd <= 2'h1;
    settle();
    hold_cmd <= 2'h3;
    settle();
    st(32'h000f_0000);
    wr(`BFP_CTRL_OFS, 32'h0, 4'hf, 2'h0);
    pwm_cmd <= 4'hf;
    sense.oc_det[1] <= 1'b1;
    settle();
    st(32'h000f_0200);
    sense.oc_det[1] <= 1'b0;
    pwm_cmd <= 4'h0;
    settle();
    st(32'h000f_0000);
    sense.temp_shut <= 1'b1;
    settle();
    st(32'h000b_0002);
    sense.temp_shut <= 1'b0;
    hold_cmd <= 2'h2;
    settle();
    st(32'h000e_0002);
    hold_cmd <= 2'h0;
    settle();
    hold_cmd <= 2'h3;
    settle();
    st(32'h000f_0000);
    repeat (30)
    begin
      @(posedge aclk);
      r = xs();
      pwm_cmd <= r[3:0];
    end
    @(posedge aclk);
    pwm_cmd <= 4'h0;
    settle();
    st(32'h000f_0000);
    pwm_cmd <= 4'h1;
    sense.boot_low[0] <= 1'b1;
    repeat (60) @(posedge aclk);
    sense.boot_low[0] <= 1'b0;
    pwm_cmd <= 4'h0;
    settle();
    st(32'h000f_0000);
    results();
  end
endmodule
